// ### rtl/dual_timer_counter_control.sv
// Purpose: Two 16-bit timer/counters with mode, gate and external interrupt flags
// Assumes: One oscillator clock, synchronous active low reset, 8-bit register port
// Notes: Interrupt output lags the status register by one clock
`timescale 1ns/100ps
`include "timer_ctrl_defines.svh"

// Function
// R1 - Gate set: timer runs only with run bit set and its interrupt pin high
// R2 - Source select clear: timer counts internal machine cycles
// R3 - Source select set: timer counts its external count pin
// R4 - Mode 00 gives a 13-bit timer/counter
// R5 - Mode 01 gives a full 16-bit timer/counter
// R6 - Mode 10 gives an 8-bit counter with automatic reload
// R7 - Timer 0 mode 11 splits into two independent 8-bit counters
// R8 - Split low byte uses timer 0 run, gate, source and flag
// R9 - Split high byte is interval timer using timer 1 run and flag
// R10 - Timer 1 mode 11 stops and holds its value
// R11 - Control register offers single-bit set, clear and test
// R12 - Trigger type 0 is low level, 1 is falling edge
// R13 - 13-bit count is high byte plus low five bits of low byte
// R14 - Reload mode low-byte overflow sets flag, reloads from high byte
// R15 - Count pin sampled each machine cycle, counts on high then low
// R16 - Overflow sets flag; vector acknowledge clears it
// R17 - Interval timing advances once per twelve-period machine cycle
module dual_timer_counter_control
   import timer_ctrl_pkg::*;
#(
   parameter int MC_DIV = `TC_MC_OSC_PERIODS
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // External pins, [0] timer 0 / line a, [1] timer 1 / line b
   input wire logic [1:0] i_ext_count_pin,
   input wire logic [1:0] i_ext_irq_gate_pin,
   // Interrupt controller
   input wire logic [3:0] i_vector_ack,
   output logic [3:0] o_flag_req,
   output logic o_irq
);
   reg_req_t req;
   logic mc_en;
   logic [1:0] cnt_fall;
   logic [1:0] irq_fall;
   logic [1:0] irq_lvl;
   logic [7:0] timer_control_r, timer_control_nxt;
   logic [7:0] timer_mode_config_r;
   logic [7:0] tl0_r, th0_r, tl1_r, th1_r;
   logic [3:0] stat_r, stat_nxt;
   logic [3:0] mask_r;
   logic [3:0] ev;
   tmode_half_t cfg0, cfg1;
   step_t st0, st1;
   logic split0, run0, run1, tick0, tick0h, tick1;
   logic ovf0, ovf1, ovf0h;
   logic [1:0] ext_ev;
   logic wr_tl0, wr_th0, wr_tl1, wr_th1;

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // Machine cycle enable, MC_DIV clocks apart, twelve by default
   mc_divider #(.DIV(MC_DIV)) u_div (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .o_tick(mc_en) // [R17]
   );

   // Count pins and interrupt pins share the same sampling
   pin_sampler #(.W(2)) u_cnt_pins (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_en(mc_en),
      .i_pin(i_ext_count_pin),
      .o_level(),
      .o_fall(cnt_fall)
   );

   pin_sampler #(.W(2)) u_irq_pins (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_en(mc_en),
      .i_pin(i_ext_irq_gate_pin),
      .o_level(irq_lvl),
      .o_fall(irq_fall)
   );

   // One count step for modes 0 to 2; split low byte is a plain 8-bit wrap
   function automatic step_t count_step(input mode_t m, input logic [7:0] tl,
                                        input logic [7:0] th);
      step_t s;
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      s = '{ovf: 1'b0, high: th, low: tl};
      c13 = {1'b0, th, tl[4:0]} + 14'h0001;
      c16 = {1'b0, th, tl} + 17'h00001;
      c8 = {1'b0, tl} + 9'h001;
      case (m)
         MODE_13BIT: begin
            s.ovf = c13[13]; // [R4]
            s.high = c13[12:5]; // [R13]
            s.low = {tl[7:5], c13[4:0]}; // [R13]
         end
         MODE_16BIT: begin
            s.ovf = c16[16]; // [R5]
            s.high = c16[15:8];
            s.low = c16[7:0];
         end
         MODE_RELOAD8: begin
            s.ovf = c8[8]; // [R6]
            s.low = c8[8] ? th : c8[7:0]; // [R14]
         end
         default: begin
            s.ovf = c8[8]; // [R7]
            s.low = c8[7:0];
         end
      endcase
      return s;
   endfunction

   // Configuration halves and software write decode
   assign cfg0 = timer_mode_config_r[3:0];
   assign cfg1 = timer_mode_config_r[7:4];
   assign wr_tl0 = req.wr && (req.addr == `TC_ADDR_T0_LOW);
   assign wr_th0 = req.wr && (req.addr == `TC_ADDR_T0_HIGH);
   assign wr_tl1 = req.wr && (req.addr == `TC_ADDR_T1_LOW);
   assign wr_th1 = req.wr && (req.addr == `TC_ADDR_T1_HIGH);

   // Run qualification and count source per timer
   assign split0 = (cfg0.mode == MODE_SPLIT);
   assign run0 = timer_control_r[`TC_TR0] && (!cfg0.gate || i_ext_irq_gate_pin[0]); // [R1] [R8]
   assign run1 = timer_control_r[`TC_TR1] && (!cfg1.gate || i_ext_irq_gate_pin[1]); // [R1]
   assign tick0 = run0 && (cfg0.ext_src ? cnt_fall[0] : mc_en); // [R2] [R3] [R8]
   assign tick1 = run1 && (cfg1.mode != MODE_SPLIT)
                  && (cfg1.ext_src ? cnt_fall[1] : mc_en); // [R2] [R3] [R10]
   assign tick0h = split0 && timer_control_r[`TC_TR1] && mc_en; // [R9]
   assign st0 = count_step(cfg0.mode, tl0_r, th0_r);
   assign st1 = count_step(cfg1.mode, tl1_r, th1_r);
   assign ovf0 = tick0 && st0.ovf;
   assign ovf1 = tick1 && st1.ovf;
   assign ovf0h = tick0h && (th0_r == 8'hff);

   // Timer 0 count registers; a software write wins over a count
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         tl0_r <= `TC_COUNT_RST;
         th0_r <= `TC_COUNT_RST;
      end else begin
         if (wr_tl0) begin
            tl0_r <= req.wdata;
         end else if (tick0) begin
            tl0_r <= st0.low;
         end
         if (wr_th0) begin
            th0_r <= req.wdata;
         end else if (tick0h) begin
            th0_r <= th0_r + 8'h01; // [R9]
         end else if (tick0 && !split0) begin
            th0_r <= st0.high; // [R7]
         end
      end
   end

   // Timer 1 count registers
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         tl1_r <= `TC_COUNT_RST;
         th1_r <= `TC_COUNT_RST;
      end else begin
         if (wr_tl1) begin
            tl1_r <= req.wdata;
         end else if (tick1) begin
            tl1_r <= st1.low;
         end
         if (wr_th1) begin
            th1_r <= req.wdata;
         end else if (tick1) begin
            th1_r <= st1.high;
         end
      end
   end

   // External flag events by trigger type
   assign ext_ev[0] = timer_control_r[`TC_IT0] ? irq_fall[0] : (mc_en && !irq_lvl[0]); // [R12]
   assign ext_ev[1] = timer_control_r[`TC_IT1] ? irq_fall[1] : (mc_en && !irq_lvl[1]); // [R12]

   // Control register: software, then vector clear, then hardware set wins
   always_comb begin
      timer_control_nxt = timer_control_r;
      if (req.wr && (req.addr == `TC_ADDR_CONTROL)) begin
         timer_control_nxt = req.wdata;
      end else if (req.wr && (req.addr == `TC_ADDR_CONTROL_BIT)) begin
         timer_control_nxt[req.wdata[2:0]] = req.wdata[`TC_BITOP_VALUE]; // [R11]
      end
      if (i_vector_ack[`TC_EV_IRQ_A]) timer_control_nxt[`TC_IE0] = 1'b0;
      if (i_vector_ack[`TC_EV_T0]) timer_control_nxt[`TC_TF0] = 1'b0; // [R16]
      if (i_vector_ack[`TC_EV_IRQ_B]) timer_control_nxt[`TC_IE1] = 1'b0;
      if (i_vector_ack[`TC_EV_T1]) timer_control_nxt[`TC_TF1] = 1'b0; // [R16]
      if (ovf0) timer_control_nxt[`TC_TF0] = 1'b1; // [R16] [R8]
      if (split0 ? ovf0h : ovf1) timer_control_nxt[`TC_TF1] = 1'b1; // [R9] [R16]
      if (ext_ev[0]) timer_control_nxt[`TC_IE0] = 1'b1;
      if (ext_ev[1]) timer_control_nxt[`TC_IE1] = 1'b1;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         timer_control_r <= `TC_CONTROL_RST;
      end else begin
         timer_control_r <= timer_control_nxt;
      end
   end

   // Mode configuration is whole-register only
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         timer_mode_config_r <= `TC_MODE_RST;
      end else if (req.wr && (req.addr == `TC_ADDR_MODE)) begin
         timer_mode_config_r <= req.wdata;
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   assign ev = {split0 ? ovf0h : ovf1, ext_ev[1], ovf0, ext_ev[0]};
   always_comb begin
      stat_nxt = stat_r;
      if (req.wr && (req.addr == `TC_ADDR_IRQ_STATUS)) begin
         stat_nxt = stat_r & ~req.wdata[3:0];
      end
      stat_nxt = stat_nxt | ev;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         stat_r <= `TC_IRQ_RST;
         mask_r <= `TC_IRQ_RST;
      end else begin
         stat_r <= stat_nxt;
         if (req.wr && (req.addr == `TC_ADDR_IRQ_MASK)) begin
            mask_r <= req.wdata[3:0];
         end
      end
   end

   // Interrupt level, registered so the output is glitch free
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(stat_r & mask_r);
      end
   end

   // Flag requests to the interrupt controller, straight from the control flops
   assign o_flag_req = {timer_control_r[`TC_TF1], timer_control_r[`TC_IE1], timer_control_r[`TC_TF0], timer_control_r[`TC_IE0]};

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
      end else if (!req.rd) begin
         o_rdata <= 8'h00;
      end else if (req.addr == `TC_ADDR_CONTROL) begin
         o_rdata <= timer_control_r; // [R11]
      end else if (req.addr == `TC_ADDR_MODE) begin
         o_rdata <= timer_mode_config_r;
      end else if (req.addr == `TC_ADDR_T0_LOW) begin
         o_rdata <= tl0_r;
      end else if (req.addr == `TC_ADDR_T0_HIGH) begin
         o_rdata <= th0_r;
      end else if (req.addr == `TC_ADDR_T1_LOW) begin
         o_rdata <= tl1_r;
      end else if (req.addr == `TC_ADDR_T1_HIGH) begin
         o_rdata <= th1_r;
      end else if (req.addr == `TC_ADDR_IRQ_STATUS) begin
         o_rdata <= {4'h0, stat_r};
      end else if (req.addr == `TC_ADDR_IRQ_MASK) begin
         o_rdata <= {4'h0, mask_r};
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // Checks next to the counting logic
   gate_hold_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R1]
      (cfg0.gate && !i_ext_irq_gate_pin[0] && !split0 && !req.wr)
      |=> ($stable(tl0_r) && $stable(th0_r)))
      else $error("timer 0 counted with gate pin low");

   interval_step_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R2]
      (mc_en && run0 && !cfg0.ext_src && cfg0.mode == MODE_16BIT && !req.wr
       && {th0_r, tl0_r} != 16'hffff)
      |=> ({th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001))
      else $error("interval timer did not advance on machine cycle");

   event_only_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R3]
      (cfg1.ext_src && !cnt_fall[1] && !req.wr) |=> $stable({th1_r, tl1_r}))
      else $error("event counter moved without a pin fall");

   pin_fall_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R15]
      (mc_en && u_cnt_pins.o_level[0] && !i_ext_count_pin[0]) |=> cnt_fall[0])
      else $error("high then low sample not flagged");

   mode13_carry_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R13]
      (tick0 && cfg0.mode == MODE_13BIT && tl0_r[4:0] == 5'h1f && th0_r != 8'hff
       && !req.wr)
      |=> (tl0_r[4:0] == 5'h00 && th0_r == $past(th0_r) + 8'h01
           && tl0_r[7:5] == $past(tl0_r[7:5])))
      else $error("13-bit carry into high byte wrong");

   reload_low_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R14]
      (tick0 && cfg0.mode == MODE_RELOAD8 && tl0_r == 8'hff && !req.wr
       && !i_vector_ack[`TC_EV_T0])
      |=> (tl0_r == $past(th0_r) && $stable(th0_r) && timer_control_r[`TC_TF0]))
      else $error("auto reload did not reload or flag");

   split_high_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R9]
      (split0 && timer_control_r[`TC_TR1] && mc_en && th0_r == 8'hff && !req.wr)
      |=> (th0_r == 8'h00 && timer_control_r[`TC_TF1]))
      else $error("split high byte overflow missed");

   t1_stop_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R10]
      (cfg1.mode == MODE_SPLIT && !req.wr) |=> $stable({th1_r, tl1_r}))
      else $error("timer 1 moved in mode 3");

   vector_clear_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R16]
      (i_vector_ack[`TC_EV_T0] && !ovf0) |=> !timer_control_r[`TC_TF0])
      else $error("vector acknowledge did not clear flag");

   bit_access_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // [R11]
      (req.wr && req.addr == `TC_ADDR_CONTROL_BIT && req.wdata[2:0] == 3'h4)
      |=> (timer_control_r[`TC_TR0] == $past(req.wdata[7])))
      else $error("single bit write to run bit failed");
endmodule

// ### inc/timer_ctrl_defines.svh
// Purpose: Offsets, field positions, reset values and counts for the timer control block
// Assumes: Included by bare name from the design files
// Notes: Register port addresses are byte indices on an 8-bit port
`ifndef TIMER_CTRL_DEFINES_SVH
`define TIMER_CTRL_DEFINES_SVH

// Register addresses
`define TC_ADDR_CONTROL 8'h00
`define TC_ADDR_MODE 8'h01
`define TC_ADDR_T0_LOW 8'h02
`define TC_ADDR_T0_HIGH 8'h03
`define TC_ADDR_T1_LOW 8'h04
`define TC_ADDR_T1_HIGH 8'h05
`define TC_ADDR_IRQ_STATUS 8'h06
`define TC_ADDR_IRQ_MASK 8'h07
`define TC_ADDR_CONTROL_BIT 8'h08

// Timer control bit positions
`define TC_TF1 7
`define TC_TR1 6
`define TC_TF0 5
`define TC_TR0 4
`define TC_IE1 3
`define TC_IT1 2
`define TC_IE0 1
`define TC_IT0 0

// Bit access write data: index in [2:0], value in [7]
`define TC_BITOP_VALUE 7

// Interrupt status bit positions, same order as the vector acknowledge
`define TC_EV_IRQ_A 0
`define TC_EV_T0 1
`define TC_EV_IRQ_B 2
`define TC_EV_T1 3

// Reset values
`define TC_CONTROL_RST 8'h00
`define TC_MODE_RST 8'h00
`define TC_COUNT_RST 8'h00
`define TC_IRQ_RST 4'h0

// Oscillator periods in one machine cycle
`define TC_MC_OSC_PERIODS 12

`endif

// ### inc/timer_ctrl_pkg.sv
// Purpose: Types shared by the timer control block
// Assumes: Nothing beyond standard SystemVerilog
// Notes: Mode codes follow declaration order 0 to 3
package timer_ctrl_pkg;

   // Operating mode of one timer
   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD8,
      MODE_SPLIT
   } mode_t;

   // One half of the timer mode configuration register
   typedef struct packed {
      logic gate;
      logic ext_src;
      mode_t mode;
   } tmode_half_t;

   // Result of one count step
   typedef struct packed {
      logic ovf;
      logic [7:0] high;
      logic [7:0] low;
   } step_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// ### rtl/mc_divider.sv
// Purpose: Machine cycle enable from the oscillator clock
// Assumes: Single clock, synchronous active low reset
// Notes: Pulse is one clock wide, once every DIV clocks
`timescale 1ns/100ps
module mc_divider #(
   parameter int DIV = 12
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Enable out
   output logic o_tick
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_r;

   // Free running count, wraps at DIV
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         cnt_r <= '0;
         o_tick <= 1'b0;
      end else begin
         o_tick <= (cnt_r == CW'(DIV - 1));
         cnt_r <= (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule

// ### rtl/pin_sampler.sv
// Purpose: Samples pins once per machine cycle and flags high-to-low changes
// Assumes: Pins synchronous to the clock
// Notes: A level shorter than a machine cycle may be missed
`timescale 1ns/100ps
module pin_sampler #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Sampling
   input wire logic i_en,
   input wire logic [W-1:0] i_pin,
   // Results
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_fall
);
   // Sample held between enables; fall pulse one clock after the enable
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_level <= '1;
         o_fall <= '0;
      end else begin
         o_fall <= i_en ? (o_level & ~i_pin) : '0; // [R15]
         if (i_en) begin
            o_level <= i_pin; // [R15]
         end
      end
   end
endmodule

// ### verification/ext_pins_model.sv
// Purpose: Far-side model of the count pins and the gate/interrupt lines
// Assumes: Bench asks for one count pulse at a time per pin
// Notes: Each pulse is a low phase then a high phase of HOLD clocks each
`timescale 1ns/100ps
module ext_pins_model #(
   parameter int HOLD = 16
) (
   // Clock
   input wire logic i_mclk,
   // Requests from the bench
   input wire logic [1:0] i_pulse,
   input wire logic [1:0] i_gate_lvl,
   // Pins
   output logic [1:0] o_count_pin,
   output logic [1:0] o_gate_pin
);
   int cnt [2];
   // Pulse timer; a request made while a pulse is still running is dropped
   always_ff @(posedge i_mclk) begin
      for (int k = 0; k < 2; k++) begin
         if (i_pulse[k] && cnt[k] == 0) begin
            cnt[k] <= 2 * HOLD;
         end else if (cnt[k] != 0) begin
            cnt[k] <= cnt[k] - 1;
         end
      end
   end
   // Idle high; each level spans a full machine cycle so none is missed
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         o_count_pin[k] = !(cnt[k] > HOLD);
      end
   end
   // Gate lines follow the level the bench asks
   assign o_gate_pin = i_gate_lvl;
endmodule

// ### verification/test_dual_timer_counter_control.sv
// Purpose: Self-checking bench for the dual timer control block
// Assumes: Machine cycle shortened to 8 clocks through MC_DIV
// Notes: Reads follow overflow quickly, before the next count step
`timescale 1ns/100ps
`include "timer_ctrl_defines.svh"
module test_dual_timer_counter_control;
   import timer_ctrl_pkg::*;
   localparam int MC = 8;
   logic i_mclk, i_reset_n, i_wr, i_rd, o_irq;
   logic [7:0] i_addr, i_wdata, o_rdata, v;
   logic [1:0] cnt_pin, gate_pin, gate_lvl, pulse;
   logic [3:0] i_vector_ack, o_flag_req;
   logic [7:0] md [3] = '{8'h00, 8'h02, 8'h01};
   int error_cnt, cmp_count, n, r;

   dual_timer_counter_control #(.MC_DIV(MC)) dual_timer_counter_control_i (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_count_pin(cnt_pin),
      .i_ext_irq_gate_pin(gate_pin), .i_vector_ack(i_vector_ack),
      .o_flag_req(o_flag_req), .o_irq(o_irq));
   ext_pins_model #(.HOLD(2 * MC)) ext_pins_model_i (
      .i_mclk(i_mclk), .i_pulse(pulse), .i_gate_lvl(gate_lvl),
      .o_count_pin(cnt_pin), .o_gate_pin(gate_pin));

   // Clock, 100 ns period
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task run(input int c);
      repeat (c) @(posedge i_mclk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask
   task bit_wr(input logic [2:0] idx, input logic val);
      wr(`TC_ADDR_CONTROL_BIT, {val, 4'h0, idx});
   endtask
   task ack(input logic [3:0] a);
      @(posedge i_mclk);
      i_vector_ack <= a;
      @(posedge i_mclk);
      i_vector_ack <= 4'h0;
   endtask
   // Bounded wait, sampled after the edge has landed
   task wait_flag(input int k);
      for (int i = 0; i < 600 && o_flag_req[k] !== 1'b1; i++) begin
         @(posedge i_mclk);
         #1;
      end
   endtask
   task reset_dut;
      i_reset_n <= 1'b0;
      gate_lvl <= 2'b11;
      run(16);
      i_reset_n <= 1'b1;
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      run(20000);
      error_cnt++;
      test_done();
   end

   initial begin
      {i_reset_n, i_wr, i_rd, i_addr, i_wdata, i_vector_ack, pulse} = '0;
      gate_lvl = 2'b11;
      r = $urandom(32'h607d);
      reset_dut();
      // Reset values, bit-write and unmapped places read zero
      wr(8'h09, 8'hff);
      for (int a = 0; a < 10; a++) begin
         rd(a[7:0], v);
         chk("reset value", v, 8'h00);
      end
      $display("test reset done");
      // Overflow in 13-bit, reload and 16-bit modes
      r = $urandom % 255;
      for (int m = 0; m < 3; m++) begin
         reset_dut();
         wr(`TC_ADDR_MODE, md[m]);
         wr(`TC_ADDR_T0_HIGH, m == 1 ? r[7:0] : 8'hff);
         wr(`TC_ADDR_T0_LOW, m == 0 ? 8'h1f : 8'hff);
         bit_wr(`TC_TR0, 1'b1);
         wait_flag(1);
         chk("overflow flag", o_flag_req[1], 1'b1);
         rd(`TC_ADDR_T0_LOW, v);
         chk("low byte", m == 0 ? v & 8'h1f : v, m == 1 ? r[7:0] : 8'h00);
         rd(`TC_ADDR_T0_HIGH, v);
         chk("high byte", v, m == 1 ? r[7:0] : 8'h00);
      end
      // Status, mask and vector clear on the last overflow
      chk("masked irq", o_irq, 1'b0);
      wr(`TC_ADDR_IRQ_MASK, 8'h02);
      run(2);
      #1;
      chk("irq", o_irq, 1'b1);
      wr(`TC_ADDR_IRQ_STATUS, 8'h02);
      run(2);
      #1;
      chk("irq cleared", o_irq, 1'b0);
      ack(4'h2);
      #1;
      chk("vector clear", o_flag_req[1], 1'b0);
      $display("test modes done");
      // Gate holds timer while its pin is low, then machine-cycle rate
      reset_dut();
      gate_lvl <= 2'b10;
      wr(`TC_ADDR_MODE, 8'h09);
      bit_wr(`TC_TR0, 1'b1);
      run(10 * MC);
      rd(`TC_ADDR_T0_LOW, v);
      chk("gated count", v, 8'h00);
      rd(`TC_ADDR_CONTROL, v);
      chk("control bits", v, 8'h12);
      gate_lvl <= 2'b11;
      run(20 * MC);
      bit_wr(`TC_TR0, 1'b0);
      rd(`TC_ADDR_T0_LOW, v);
      chk("tick rate", v >= 8'd19 && v <= 8'd21, 1'b1);
      $display("test gate done");
      // Event counting on both count pins
      reset_dut();
      wr(`TC_ADDR_MODE, 8'h55);
      bit_wr(`TC_TR0, 1'b1);
      bit_wr(`TC_TR1, 1'b1);
      n = 1 + $urandom % 5;
      repeat (n) begin
         @(posedge i_mclk);
         pulse <= 2'b11;
         @(posedge i_mclk);
         pulse <= 2'b00;
         run(6 * MC);
      end
      rd(`TC_ADDR_T0_LOW, v);
      chk("events t0", v, n[7:0]);
      rd(`TC_ADDR_T1_LOW, v);
      chk("events t1", v, n[7:0]);
      $display("test events done");
      // Split timer 0 with timer 1 held
      reset_dut();
      wr(`TC_ADDR_MODE, 8'h33);
      wr(`TC_ADDR_T0_HIGH, 8'hff);
      wr(`TC_ADDR_T0_LOW, 8'hfe);
      wr(`TC_ADDR_T1_LOW, 8'h20);
      bit_wr(`TC_TR1, 1'b1);
      wait_flag(3);
      chk("split high flag", o_flag_req[3:1], 3'b100);
      rd(`TC_ADDR_T0_HIGH, v);
      chk("split high", v, 8'h00);
      rd(`TC_ADDR_T0_LOW, v);
      chk("split low idle", v, 8'hfe);
      rd(`TC_ADDR_T1_LOW, v);
      chk("timer 1 held", v, 8'h20);
      rd(`TC_ADDR_MODE, v);
      chk("mode readback", v, 8'h33);
      bit_wr(`TC_TR0, 1'b1);
      wait_flag(1);
      chk("split low flag", o_flag_req[1], 1'b1);
      $display("test split done");
      // Level versus falling-edge detection, cleared while the line stays low
      reset_dut();
      for (int t = 0; t < 2; t++) begin
         bit_wr(`TC_IT0, t[0]);
         run(3 * MC);
         gate_lvl <= 2'b10;
         wait_flag(0);
         chk("line flag", o_flag_req[0], 1'b1);
         ack(4'h1);
         run(3 * MC);
         #1;
         chk("flag after clear", o_flag_req[0], t == 0);
         gate_lvl <= 2'b11;
         ack(4'h1);
      end
      $display("test lines done");
      test_done();
   end
endmodule
